// File: src/backup_charge_pkg.sv
/*
 * Shared constants, types and decode helpers for the backup cell charger control.
 * Assumes a single 40 MHz clock domain and a 32-bit AXI4-Lite register slave.
 */
package backup_charge_pkg;

   // Register byte addresses
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_VOLT       = 8'h04;
   localparam logic [7:0]  ADDR_STATUS     = 8'h08;

   // Field positions
   localparam int unsigned CTRL_ON_BIT     = 0;
   localparam int unsigned CTRL_OFF_BIT    = 1;
   localparam int unsigned STAT_EN_BIT     = 0;
   localparam int unsigned STAT_HI_BIT     = 1;
   localparam int unsigned STAT_PS_LSB     = 2;
   localparam int unsigned STAT_UV_BIT     = 4;
   localparam int unsigned STAT_MV_LSB     = 16;

   // Reset values and bus answers
   localparam logic        ENABLE_RESET    = 1'b0;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // Target voltage decode, millivolts
   localparam logic [3:0]  CODE_LOWEST     = 4'h0;
   localparam logic [3:0]  CODE_HIGHEST    = 4'hF;
   localparam logic [11:0] MV_LOWEST       = 12'h708;
   localparam logic [11:0] MV_STEP_BASE    = 12'h76C;
   localparam logic [11:0] MV_STEP         = 12'h064;
   localparam logic [11:0] MV_HIGHEST      = 12'hE10;

   typedef enum logic [1:0] {
      PS_OTHER,
      PS_RUN,
      PS_STANDBY,
      PS_QUIET_OFF
   } power_state_t;

   typedef struct packed {
      logic        enable;
      logic        high_current;
      logic [3:0]  code;
      logic [11:0] target_mv;
   } charge_ctrl_t;

   function automatic logic [11:0] code_to_mv(input logic [3:0] code);
      logic [15:0] prod;
      prod = 16'(code) * 16'(MV_STEP);
      if (code == CODE_LOWEST) begin
         return MV_LOWEST;
      end else if (code == CODE_HIGHEST) begin
         return MV_HIGHEST;
      end else begin
         return 12'(MV_STEP_BASE + prod[11:0]);
      end
   endfunction : code_to_mv

   function automatic logic charge_allowed(input power_state_t ps, input logic on_en,
                                           input logic off_en);
      case (ps)
         PS_RUN, PS_STANDBY: return on_en;
         PS_QUIET_OFF:       return off_en;
         default:            return 1'b0;
      endcase
   endfunction : charge_allowed

endpackage : backup_charge_pkg

// File: src/charge_select.sv
/*
 * Combinational selection of charger enable, current level and target voltage.
 * Assumes the power state comes from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module charge_select
   import backup_charge_pkg::*;
(
   input  wire power_state_t power_state_in,   // Current power state
   input  wire logic         on_enable_in,     // System-on charge enable
   input  wire logic         offstate_en_in,   // Quiet off charge enable
   input  wire logic [3:0]   code_in,          // Target voltage code
   output var charge_ctrl_t  ctrl_out          // Selected charger settings
);

   always_comb begin
      ctrl_out              = '0;
      // Other power states force the charger off
      ctrl_out.enable       = charge_allowed(power_state_in, on_enable_in,
                                             offstate_en_in);
      // Only run mode draws the high current; standby and quiet off stay low
      ctrl_out.high_current = ctrl_out.enable && (power_state_in == PS_RUN);
      ctrl_out.code         = code_in;
      ctrl_out.target_mv    = code_to_mv(code_in);
   end

endmodule : charge_select

`default_nettype wire

// File: src/backup_charger_ctrl.sv
/*
 * Backup cell charger control with an AXI4-Lite register slave.
 * Assumes power state and fuse value come from same-clock logic; the
 * undervoltage comparator level is asynchronous and is synchronised here.
 */
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module backup_charger_ctrl
   import backup_charge_pkg::*;
(
   input  wire logic         clk_in,                      // 40 MHz clock
   input  wire logic         resetn_in,                   // Async reset, active low
   input  wire logic         ce_in,                       // Clock enable
   input  wire power_state_t power_state_in,              // Device power state
   input  wire logic         uv_level_in,                 // Undervoltage comparator level
   input  wire logic [3:0]   fused_backup_target_voltage_in, // Fused default code
   output var charge_ctrl_t  charge_ctrl_out,             // Registered charger settings
   input  wire logic         awvalid_in,                  // AXI write address valid
   output logic              awready_out,                 // AXI write address ready
   input  wire logic [7:0]   awaddr_in,                   // AXI write address
   input  wire logic         wvalid_in,                   // AXI write data valid
   output logic              wready_out,                  // AXI write data ready
   input  wire logic [31:0]  wdata_in,                    // AXI write data
   input  wire logic [3:0]   wstrb_in,                    // AXI write strobes
   output logic              bvalid_out,                  // AXI write response valid
   input  wire logic         bready_in,                   // AXI write response ready
   output logic [1:0]        bresp_out,                   // AXI write response
   input  wire logic         arvalid_in,                  // AXI read address valid
   output logic              arready_out,                 // AXI read address ready
   input  wire logic [7:0]   araddr_in,                   // AXI read address
   output logic              rvalid_out,                  // AXI read data valid
   input  wire logic         rready_in,                   // AXI read data ready
   output logic [31:0]       rdata_out,                   // AXI read data
   output logic [1:0]        rresp_out                    // AXI read response
);

   logic         uv_meta_q;
   logic         uv_sync_q;
   logic         uv_prev_q;
   logic         uv_cross;
   logic         fuse_load_q;
   logic         on_enable_q;
   logic         offstate_en_q;
   logic [3:0]   code_q;
   logic [7:0]   waddr_q;
   logic [31:0]  wdata_q;
   logic         wlane0_q;
   logic         wr_fire;
   logic         wr_hit;
   charge_ctrl_t sel_ctrl;
   logic [31:0]  rd_word;
   logic         rd_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // Undervoltage synchroniser; any change of level counts as a crossing

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         uv_meta_q <= 1'b0;
         uv_sync_q <= 1'b0;
         uv_prev_q <= 1'b0;
      end else if (ce_in) begin
         uv_meta_q <= uv_level_in;
         uv_sync_q <= uv_meta_q;
         uv_prev_q <= uv_sync_q;
      end
   end

   assign uv_cross = uv_sync_q ^ uv_prev_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Control bits; a crossing beats a host write in the same cycle

   assign wr_fire = !awready_out && !wready_out && !bvalid_out;
   assign wr_hit  = (waddr_q == ADDR_CTRL) || (waddr_q == ADDR_VOLT);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         on_enable_q   <= ENABLE_RESET;
         offstate_en_q <= ENABLE_RESET;
      end else if (ce_in) begin
         if (uv_cross) begin
            on_enable_q   <= 1'b0;
            offstate_en_q <= 1'b0;
         end else if (wr_fire && wlane0_q && waddr_q == ADDR_CTRL) begin
            on_enable_q   <= wdata_q[CTRL_ON_BIT];
            offstate_en_q <= wdata_q[CTRL_OFF_BIT];
         end
      end
   end

   // Fuse code is reloaded after reset and on each crossing, like any default
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fuse_load_q <= 1'b1;
         code_q      <= CODE_LOWEST;
      end else if (ce_in) begin
         fuse_load_q <= 1'b0;
         if (fuse_load_q || uv_cross) begin
            code_q <= fused_backup_target_voltage_in;
         end else if (wr_fire && wlane0_q && waddr_q == ADDR_VOLT) begin
            code_q <= wdata_q[3:0];
         end
      end
   end

   charge_select u_select (
      .power_state_in (power_state_in),
      .on_enable_in   (on_enable_q),
      .offstate_en_in (offstate_en_q),
      .code_in        (code_q),
      .ctrl_out       (sel_ctrl)
   );

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         charge_ctrl_out <= '0;
      end else if (ce_in) begin
         charge_ctrl_out <= sel_ctrl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write: address and data taken in either order, then one response

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         awready_out <= 1'b1;
         wready_out  <= 1'b1;
         bvalid_out  <= 1'b0;
         bresp_out   <= RESP_OKAY;
         waddr_q     <= 8'h00;
         wdata_q     <= 32'h0000_0000;
         wlane0_q    <= 1'b0;
      end else if (ce_in) begin
         if (awready_out && awvalid_in) begin
            awready_out <= 1'b0;
            waddr_q     <= awaddr_in;
         end
         if (wready_out && wvalid_in) begin
            wready_out <= 1'b0;
            wdata_q    <= wdata_in;
            wlane0_q   <= wstrb_in[0];
         end
         if (wr_fire) begin
            bvalid_out <= 1'b1;
            bresp_out  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_out && bready_in) begin
            bvalid_out  <= 1'b0;
            awready_out <= 1'b1;
            wready_out  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read: one cycle to data; status shows the block's live state

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (araddr_in)
         ADDR_CTRL: begin
            rd_word[CTRL_ON_BIT]  = on_enable_q;
            rd_word[CTRL_OFF_BIT] = offstate_en_q;
         end
         ADDR_VOLT: rd_word[3:0] = code_q;
         ADDR_STATUS: begin
            rd_word[STAT_EN_BIT]                 = charge_ctrl_out.enable;
            rd_word[STAT_HI_BIT]                 = charge_ctrl_out.high_current;
            rd_word[STAT_PS_LSB +: 2]            = power_state_in;
            rd_word[STAT_UV_BIT]                 = uv_sync_q;
            rd_word[STAT_MV_LSB +: 12]           = charge_ctrl_out.target_mv;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         arready_out <= 1'b1;
         rvalid_out  <= 1'b0;
         rdata_out   <= 32'h0000_0000;
         rresp_out   <= RESP_OKAY;
      end else if (ce_in) begin
         if (arready_out && arvalid_in) begin
            arready_out <= 1'b0;
            rvalid_out  <= 1'b1;
            rdata_out   <= rd_word;
            rresp_out   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_out && rready_in) begin
            rvalid_out  <= 1'b0;
            arready_out <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks; every assertion is guarded by a clock-enabled previous cycle, the covers are not

   property p_on_enable;
      @(posedge clk_in) disable iff (!resetn_in)
      $past(ce_in) && ($past(power_state_in) inside {PS_RUN, PS_STANDBY})
         |-> charge_ctrl_out.enable == $past(on_enable_q);
   endproperty
   a_on_enable: assert property (p_on_enable) else $error("on-state enable wrong");

   property p_uv_clear_on;
      @(posedge clk_in) disable iff (!resetn_in)
      ce_in && uv_cross |=> !on_enable_q;
   endproperty
   a_uv_clear_on: assert property (p_uv_clear_on) else $error("on enable not cleared");

   property p_run_high;
      @(posedge clk_in) disable iff (!resetn_in)
      ce_in && power_state_in == PS_RUN && on_enable_q |=> charge_ctrl_out.high_current;
   endproperty
   a_run_high: assert property (p_run_high) else $error("run not high current");

   property p_low_current;
      @(posedge clk_in) disable iff (!resetn_in)
      ce_in && power_state_in != PS_RUN |=> !charge_ctrl_out.high_current;
   endproperty
   a_low_current: assert property (p_low_current) else $error("high current outside run");

   property p_off_enable;
      @(posedge clk_in) disable iff (!resetn_in)
      ce_in && power_state_in == PS_QUIET_OFF |=> charge_ctrl_out.enable == $past(offstate_en_q);
   endproperty
   a_off_enable: assert property (p_off_enable) else $error("off-state enable wrong");

   property p_uv_clear_off;
      @(posedge clk_in) disable iff (!resetn_in)
      ce_in && uv_cross |=> !offstate_en_q ##1 (!offstate_en_q || $past(wr_fire));
   endproperty
   a_uv_clear_off: assert property (p_uv_clear_off) else $error("off enable not cleared");

   // The output still holds its reset zeros at the first edge after release
   property p_decode;
      @(posedge clk_in) disable iff (!resetn_in)
      $past(resetn_in) && $past(ce_in)
         |-> charge_ctrl_out.target_mv == code_to_mv($past(code_q))
             && ($past(code_q) != CODE_HIGHEST || charge_ctrl_out.target_mv == MV_HIGHEST);
   endproperty
   a_decode: assert property (p_decode) else $error("target voltage decode wrong");

   property p_fuse_default;
      @(posedge clk_in) disable iff (!resetn_in)
      ce_in && (fuse_load_q || uv_cross) |=> code_q == $past(fused_backup_target_voltage_in);
   endproperty
   a_fuse_default: assert property (p_fuse_default) else $error("fused default not loaded");

   property p_other_off;
      @(posedge clk_in) disable iff (!resetn_in)
      ce_in && power_state_in == PS_OTHER |=> !charge_ctrl_out.enable && !charge_ctrl_out.high_current;
   endproperty
   a_other_off: assert property (p_other_off) else $error("charger on in other state");

   c_run_charge:  cover property (@(posedge clk_in) disable iff (!resetn_in)
                                  charge_ctrl_out.enable && charge_ctrl_out.high_current);
   c_off_charge:  cover property (@(posedge clk_in) disable iff (!resetn_in)
                                  power_state_in == PS_QUIET_OFF ##1 charge_ctrl_out.enable);
   c_uv_cut:      cover property (@(posedge clk_in) disable iff (!resetn_in)
                                  on_enable_q ##1 uv_cross);

endmodule : backup_charger_ctrl

`default_nettype wire

// File: tb/axi_lite_host.sv
/*
 * AXI4-Lite host model: one register write or read at a time, driven by tasks.
 * Assumes the slave shares clk_in and answers within the wait bound.
 */
`timescale 1ns/1ps
`default_nettype none

module axi_lite_host (
   input  wire logic        clk_in,      // Bus clock
   output logic             awvalid_out, // AW valid
   input  wire logic        awready_in,  // AW ready
   output logic [7:0]       awaddr_out,  // AW address
   output logic             wvalid_out,  // W valid
   input  wire logic        wready_in,   // W ready
   output logic [31:0]      wdata_out,   // W data
   output logic [3:0]       wstrb_out,   // W strobes
   input  wire logic        bvalid_in,   // B valid
   output logic             bready_out,  // B ready
   input  wire logic [1:0]  bresp_in,    // B response
   output logic             arvalid_out, // AR valid
   input  wire logic        arready_in,  // AR ready
   output logic [7:0]       araddr_out,  // AR address
   input  wire logic        rvalid_in,   // R valid
   output logic             rready_out,  // R ready
   input  wire logic [31:0] rdata_in,    // R data
   input  wire logic [1:0]  rresp_in,    // R response
   output logic             timeout_out  // A wait ran out
);

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
      {awaddr_out, araddr_out, wstrb_out, timeout_out} = 21'h0_0000;
      wdata_out = 32'h0000_0000;
   end

   // Released payloads are inverted so a stale value is never mistaken for live
   task automatic write(input logic [7:0] addr, input logic [31:0] data,
                        output logic [1:0] resp);
      resp = 2'bxx;
      @(posedge clk_in);
      awvalid_out <= 1'b1;
      awaddr_out  <= addr;
      wvalid_out  <= 1'b1;
      wdata_out   <= data;
      wstrb_out   <= 4'hF;
      bready_out  <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(posedge clk_in);
         if (awvalid_out && awready_in) begin
            awvalid_out <= 1'b0;
            awaddr_out  <= ~addr;
         end
         if (wvalid_out && wready_in) begin
            wvalid_out <= 1'b0;
            wdata_out  <= ~data;
         end
         if (bvalid_in) begin
            bready_out <= 1'b0;
            resp = bresp_in;
            return;
         end
      end
      // Blocking, so the caller sees the timeout as soon as the task returns
      timeout_out = 1'b1;
   endtask : write

   task automatic read(input logic [7:0] addr, output logic [31:0] data,
                       output logic [1:0] resp);
      resp = 2'bxx;
      data = 32'hxxxx_xxxx;
      @(posedge clk_in);
      arvalid_out <= 1'b1;
      araddr_out  <= addr;
      rready_out  <= 1'b1;
      for (int n = 0; n < 64; n++) begin
         @(posedge clk_in);
         if (arvalid_out && arready_in) begin
            arvalid_out <= 1'b0;
            araddr_out  <= ~addr;
         end
         if (rvalid_in) begin
            rready_out <= 1'b0;
            data = rdata_in;
            resp = rresp_in;
            return;
         end
      end
      timeout_out = 1'b1;
   endtask : read

endmodule : axi_lite_host

`default_nettype wire

// File: tb/backup_cell_charger_control_bench.sv
/*
 * Self-checking bench for the backup cell charger control.
 * Assumes the register map of the package and the slave's bus latencies; ce_in driven here.
 */
`timescale 1ns/1ps
`default_nettype none

module backup_cell_charger_control_bench
   import backup_charge_pkg::*;
();

   localparam logic [3:0] FUSE_CODE = 4'hB;

   logic         clk = 1'b0;
   logic         resetn = 1'b0;
   power_state_t ps = PS_OTHER;
   logic         uv = 1'b0;
   logic         ce = 1'b1;
   charge_ctrl_t ctrl;
   logic         awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
   logic [7:0]   awa, ara;
   logic [31:0]  wd, rd_data;
   logic [3:0]   ws;
   logic [1:0]   bresp, rresp, resp;
   logic [31:0]  data;
   int           n_fail = 0;
   int           samples_checked = 0;

   always #12.5 clk = ~clk;

   backup_charger_ctrl i_dut (.clk_in(clk), .resetn_in(resetn), .ce_in(ce),
      .power_state_in(ps), .uv_level_in(uv), .fused_backup_target_voltage_in(FUSE_CODE),
      .charge_ctrl_out(ctrl), .awvalid_in(awv), .awready_out(awr), .awaddr_in(awa),
      .wvalid_in(wv), .wready_out(wr_rdy), .wdata_in(wd), .wstrb_in(ws), .bvalid_out(bv),
      .bready_in(br), .bresp_out(bresp), .arvalid_in(arv), .arready_out(arr),
      .araddr_in(ara), .rvalid_out(rv), .rready_in(rr), .rdata_out(rd_data),
      .rresp_out(rresp));

   axi_lite_host i_host (.clk_in(clk), .awvalid_out(awv), .awready_in(awr),
      .awaddr_out(awa), .wvalid_out(wv), .wready_in(wr_rdy), .wdata_out(wd),
      .wstrb_out(ws), .bvalid_in(bv), .bready_out(br), .bresp_in(bresp),
      .arvalid_out(arv), .arready_in(arr), .araddr_out(ara), .rvalid_in(rv),
      .rready_out(rr), .rdata_in(rd_data), .rresp_in(rresp), .timeout_out());

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic bus_guard();
      if (i_host.timeout_out !== 1'b0) begin
         n_fail++;
         end_of_test();
      end
   endtask : bus_guard

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_host.write(a, d, resp);
      bus_guard();
   endtask : wr

   task automatic rd(input logic [7:0] a);
      i_host.read(a, data, resp);
      bus_guard();
   endtask : rd

   // Target voltage in millivolts, from the code table
   function automatic logic [11:0] exp_mv(input logic [3:0] c);
      if (c == 4'h0) return 12'h708;
      if (c == 4'hF) return 12'hE10;
      return 12'(12'h76C + 12'h064 * 12'(c));
   endfunction : exp_mv

   task automatic ctl_is(input logic en, input logic hi, input logic [3:0] c);
      repeat (2) @(posedge clk);
      check("charger", 32'(ctrl), 32'({en, hi, c, exp_mv(c)}));
   endtask : ctl_is

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_default();
      // Fused code is taken one edge after release and shown one edge later
      @(posedge clk);
      ctl_is(1'b0, 1'b0, FUSE_CODE);
      rd(ADDR_VOLT);
      check("volt", data, 32'(FUSE_CODE));
      check("rresp ok", 32'(resp), 32'(RESP_OKAY));
      $display("test default done");
   endtask : t_default

   task automatic t_on();
      ps <= PS_RUN;
      wr(ADDR_CTRL, 32'h0000_0001);
      check("bresp ok", 32'(resp), 32'(RESP_OKAY));
      ctl_is(1'b1, 1'b1, FUSE_CODE);
      ps <= PS_STANDBY;
      ctl_is(1'b1, 1'b0, FUSE_CODE);
      rd(ADDR_STATUS);
      check("status", data, 32'({4'h0, exp_mv(FUSE_CODE), 11'h000, 1'b0, 2'h2, 2'h1}));
      wr(ADDR_CTRL, 32'h0000_0000);
      ctl_is(1'b0, 1'b0, FUSE_CODE);
      $display("test system-on done");
   endtask : t_on

   task automatic t_off();
      ps <= PS_RUN;
      wr(ADDR_CTRL, 32'h0000_0002);
      ctl_is(1'b0, 1'b0, FUSE_CODE);
      ps <= PS_QUIET_OFF;
      ctl_is(1'b1, 1'b0, FUSE_CODE);
      ps <= PS_STANDBY;
      ctl_is(1'b0, 1'b0, FUSE_CODE);
      $display("test off-state done");
   endtask : t_off

   task automatic t_other();
      wr(ADDR_CTRL, 32'h0000_0003);
      ps <= PS_OTHER;
      ctl_is(1'b0, 1'b0, FUSE_CODE);
      ps <= PS_RUN;
      ctl_is(1'b1, 1'b1, FUSE_CODE);
      // Clock enable low freezes the output although the state leaves run
      ce <= 1'b0;
      ps <= PS_OTHER;
      ctl_is(1'b1, 1'b1, FUSE_CODE);
      ce <= 1'b1;
      ctl_is(1'b0, 1'b0, FUSE_CODE);
      ps <= PS_RUN;
      $display("test other state done");
   endtask : t_other

   task automatic t_codes();
      for (int c = 0; c < 16; c++) begin
         wr(ADDR_VOLT, 32'(c));
         ctl_is(1'b1, 1'b1, 4'(c));
      end
      $display("test codes done");
   endtask : t_codes

   // Both crossing directions must clear the enables and restore the fused code
   task automatic t_uv();
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_CTRL, 32'h0000_0003);
         wr(ADDR_VOLT, 32'h0000_0002);
         uv <= ~uv;
         repeat (6) @(posedge clk);
         rd(ADDR_CTRL);
         check("ctrl", data, 32'h0000_0000);
         ctl_is(1'b0, 1'b0, FUSE_CODE);
         rd(ADDR_STATUS);
         check("uv level", 32'(data[STAT_UV_BIT]), 32'(uv));
      end
      $display("test undervoltage done");
   endtask : t_uv

   task automatic t_bus();
      wr(8'h0C, 32'h0000_0003);
      check("bresp", 32'(resp), 32'(RESP_SLVERR));
      rd(8'h0C);
      check("rresp", 32'(resp), 32'(RESP_SLVERR));
      check("rdata", data, 32'h0000_0000);
      $display("test unmapped done");
   endtask : t_bus

   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_default();
      t_on();
      t_off();
      t_other();
      t_codes();
      t_uv();
      t_bus();
      end_of_test();
   end

endmodule : backup_cell_charger_control_bench

`default_nettype wire
